// ==== sim/stx_ctrl_props.sv ====
// checker: port timing relations of the transceiver mode control
`timescale 1ns/1ps
module stx_ctrl_props #(
    parameter int NUM_TX  = 3,
    parameter int NUM_RX  = 5,
    parameter int NUM_MON = 2
) (
    input wire logic               mclk,
    input wire logic               rst_b,
    input wire logic               keep_on_request,
    input wire logic               hard_off_n,
    input wire logic               rx_disable,
    input wire logic [NUM_RX-1:0]  rx_line_valid,
    input wire logic [NUM_RX-1:0]  rx_line_level,
    input wire logic [1:0]         rail_above_limit,
    input wire logic [NUM_TX-1:0]  tx_line_oe,
    input wire logic [NUM_RX-1:0]  rx_logic_out,
    input wire logic [NUM_RX-1:0]  rx_logic_oe,
    input wire logic [NUM_MON-1:0] monitor_rx_out,
    input wire logic               line_active,
    input wire logic [1:0]         pump_on,
    input wire logic [1:0]         rail_tied,
    input wire logic               tx_ready
);
    localparam int IDLE_N = 1200;
    localparam int WAKE_N = 4000;
    logic [15:0] quiet_reg;
    logic [15:0] on_reg;
    // quiet run saturates so a long idle spell cannot wrap to zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_reg <= 16'h0;
            on_reg    <= 16'h0;
        end else begin
            quiet_reg <= (|rx_line_valid) ? 16'h0 : quiet_reg + {15'h0, ~&quiet_reg};
            on_reg    <= tx_line_oe[0] ? on_reg + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_off_tx: assert property ((!hard_off_n)[*3] |-> tx_line_oe == '0 && !tx_ready)
        else $error("transmitters enabled while hard-off held");
    chk_off_rails: assert property ((!hard_off_n)[*4] |-> rail_tied == 2'b11 && pump_on == 2'b00)
        else $error("rails not tied or pump running in shutdown");
    chk_pump_limit: assert property ((rail_above_limit[0])[*3] |-> !pump_on[0])
        else $error("pump runs above limit");
    chk_rx_invert: assert property ($past(rst_b) |-> rx_logic_out == ~$past(rx_line_level))
        else $error("receiver output not inverted line");
    chk_monitor_copy: assert property ($past(rst_b) |-> monitor_rx_out == $past(rx_line_level[NUM_MON-1:0]))
        else $error("monitor output not a copy of line");
    chk_flag_follow: assert property ($past(rst_b) |-> line_active == $past(|rx_line_valid))
        else $error("activity flag wrong");
    chk_rx_disable: assert property ((rx_disable)[*3] |-> rx_logic_oe == '0)
        else $error("receiver outputs driven while disabled");
    chk_idle_gap: assert property ($fell(tx_line_oe[0]) && hard_off_n && $past(hard_off_n) |-> quiet_reg >= IDLE_N - 1)
        else $error("power-down before idle interval");
    chk_wake_fast: assert property ((hard_off_n && |rx_line_valid)[*4] |-> tx_line_oe == '1)
        else $error("no wake on valid level");
    chk_keep_on: assert property ((hard_off_n && keep_on_request)[*4] |-> tx_line_oe == '1)
        else $error("keep-on did not hold transmitters");
    chk_wake_time: assert property ($rose(tx_ready) |-> on_reg >= WAKE_N - 1 && on_reg <= WAKE_N + 2)
        else $error("ready at wrong time after wake");
    cov_ready: cover property ($rose(tx_ready));
    cov_idle: cover property ($fell(tx_line_oe[0]) && hard_off_n);
    cov_pump: cover property (rail_above_limit[0] && !pump_on[0] && !rail_tied[0]);
endmodule

bind stx_ctrl stx_ctrl_props #(.NUM_TX(NUM_TX), .NUM_RX(NUM_RX), .NUM_MON(NUM_MON)) i_stx_ctrl_props (
    .mclk, .rst_b, .keep_on_request, .hard_off_n, .rx_disable, .rx_line_valid, .rx_line_level,
    .rail_above_limit, .tx_line_oe, .rx_logic_out, .rx_logic_oe, .monitor_rx_out, .line_active,
    .pump_on, .rail_tied, .tx_ready);

// ==== sim/stx_ctrl_tb_top.sv ====
// testbench: mode control scenarios checked against fixed expected values
`timescale 1ns/1ps
module stx_ctrl_tb_top;
    logic                  mclk;
    logic                  rst_b;
    stx_pkg::stx_apb_req_t apb_req;
    stx_pkg::stx_apb_rsp_t apb_rsp;
    logic                  power_down_n;
    logic                  force_wake;
    logic                  keep_on_request;
    logic                  hard_off_n;
    logic                  rx_disable;
    logic [4:0]            rx_line_valid;
    logic [4:0]            rx_line_level;
    logic [1:0]            rail_above_limit;
    logic [2:0]            tx_line_out;
    logic [2:0]            tx_line_oe;
    logic [4:0]            rx_logic_out;
    logic [4:0]            rx_logic_oe;
    logic [1:0]            monitor_rx_out;
    logic                  line_active;
    logic [1:0]            pump_on;
    logic [1:0]            rail_tied;
    logic                  tx_ready;
    logic [31:0]           rd;
    logic                  err;
    int                    fails = 0;
    int                    checks_done = 0;
    int                    cyc = 0;
    int                    seed;
    int                    n;
    logic [31:0]           d;
    stx_pmu_model i_stx_pmu_model (.power_down_n, .force_wake, .keep_on_request, .hard_off_n);
    stx_ctrl i_stx_ctrl (.mclk, .rst_b, .apb_req, .apb_rsp, .keep_on_request, .hard_off_n,
        .rx_disable, .rx_line_valid, .rx_line_level, .rail_above_limit, .tx_line_out, .tx_line_oe,
        .rx_logic_out, .rx_logic_oe, .monitor_rx_out, .line_active, .pump_on, .rail_tied, .tx_ready);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic test_done;
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ceiling well above the roughly 7600 cycles the sequence needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        forever begin
            @(posedge mclk);
            if (apb_rsp.pready === 1'b1) break;
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic wait_for(input logic sel, input logic [2:0] v);
        n = 0;
        while ((sel ? {2'b00, tx_ready} : tx_line_oe) !== v && n < 20000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask
    initial begin
        apb_req = '0;
        rst_b = 1'b0;
        power_down_n = 1'b1;
        force_wake = 1'b0;
        rx_disable = 1'b0;
        rx_line_valid = '0;
        rx_line_level = '0;
        rail_above_limit = '0;
        seed = 83223;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(negedge mclk);
        chk("rails_off", {tx_line_oe, rail_tied}, 5'b00011);
        apb(1'b0, stx_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", {err, rd[30:0]}, {28'h0, stx_pkg::CTRL_RESET});
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            rx_line_level <= 5'($random(seed));
            settle(1);
            chk("rx_inv", rx_logic_out, {~rx_line_level});
            chk("monitor", monitor_rx_out, rx_line_level[1:0]);
        end
        @(posedge mclk);
        rx_line_valid <= 5'h04;
        wait_for(1'b1, 3'h1);
        chk("wake_time", n >= stx_pkg::WAKE_CYCLES + 1 && n <= stx_pkg::WAKE_CYCLES + 4, 1);
        for (int i = 0; i < 2; i++) begin
            d = $random(seed);
            apb(1'b1, stx_pkg::ADDR_TXDATA, d);
            settle(2);
            chk("tx_inv", tx_line_out, {~d[2:0]});
        end
        // a limit on one rail must stop only that pump
        @(posedge mclk);
        rail_above_limit <= 2'b01;
        settle(4);
        chk("pump_p", pump_on, 2'b10);
        @(posedge mclk);
        rail_above_limit <= 2'b10;
        settle(4);
        chk("pump_n", pump_on, 2'b01);
        @(posedge mclk);
        rail_above_limit <= 2'b00;
        rx_line_valid <= 5'h00;
        repeat (800) @(posedge mclk);
        rx_line_valid <= 5'h01;
        @(posedge mclk);
        rx_line_valid <= 5'h00;
        wait_for(1'b0, 3'h0);
        chk("idle_gap", n >= stx_pkg::IDLE_CYCLES && n <= stx_pkg::IDLE_CYCLES + 4, 1);
        settle(0);
        chk("flag_idle", line_active, 1'b0);
        @(posedge mclk);
        rx_line_valid <= 5'h10;
        wait_for(1'b0, 3'h7);
        chk("wake_fast", n <= 4, 1);
        @(posedge mclk);
        force_wake <= 1'b1;
        rx_line_valid <= 5'h00;
        settle(1500);
        chk("keep_on", tx_line_oe, 3'h7);
        @(posedge mclk);
        power_down_n <= 1'b0;
        settle(4);
        chk("hard_off", {tx_line_oe, rail_tied, pump_on, rx_logic_oe}, 12'h19f);
        apb(1'b0, stx_pkg::ADDR_STATUS, 32'h0);
        chk("status_off", {err, rd[30:0]}, 32'h00000020);
        @(posedge mclk);
        rx_disable <= 1'b1;
        rx_line_valid <= 5'h02;
        settle(3);
        chk("rx_dis", {rx_logic_oe, line_active}, 6'h01);
        @(posedge mclk);
        rx_disable <= 1'b0;
        apb(1'b1, stx_pkg::ADDR_CTRL, 32'ha);
        settle(3);
        chk("multi_off", rx_logic_oe, 5'h00);
        @(posedge mclk);
        power_down_n <= 1'b1;
        settle(4);
        chk("multi_on", rx_logic_oe, 5'h1f);
        test_done();
    end
endmodule

// ==== sim/stx_pmu_model.sv ====
// partner model: power-management controller driving the mode inputs
`timescale 1ns/1ps
module stx_pmu_model (
    input  wire logic power_down_n,
    input  wire logic force_wake,
    output logic      keep_on_request,
    output logic      hard_off_n
);
    // one active-low line feeds both controls; force_wake holds ports on to rouse a remote
    assign hard_off_n      = power_down_n;
    assign keep_on_request = power_down_n & force_wake;
endmodule

// ==== src/stx_ctrl.sv ====
// module: mode and output-enable control of a serial line transceiver
// Contract
// - each pump runs only while its rail magnitude is below the limit.
// - transmitters invert logic input onto the line.
// - transmitters released when hard-off low or idle power-down taken.
// - receivers invert line onto three-state logic outputs.
// - small variants release receiver outputs while disable is high.
// - small variants keep receivers active in shutdown unless disabled.
// - multi variant releases main receivers only while hard-off low.
// - multi variant monitor outputs are always driven, non-inverting.
// - activity flag high when any input valid, low otherwise.
// - activity flag works in every mode.
// - idle power-down allowed only with keep-on low and hard-off high.
// - power-down after 30 us with no valid input.
// - wake from idle power-down as soon as any input valid.
// - keep-on with hard-off high forces transmitters on.
// - in shutdown pumps off, rails tied, transmitters released.
// - full operation 100 us after leaving shutdown.
// - hard-off low overrides all automatic logic and keep-on.
`timescale 1ns/1ps
module stx_ctrl #(
    parameter int NUM_TX  = stx_pkg::NUM_TX,
    parameter int NUM_RX  = stx_pkg::NUM_RX,
    parameter int NUM_MON = stx_pkg::NUM_MON
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire stx_pkg::stx_apb_req_t apb_req,
    output stx_pkg::stx_apb_rsp_t     apb_rsp,
    input  wire logic                 keep_on_request,
    input  wire logic                 hard_off_n,
    input  wire logic                 rx_disable,
    input  wire logic [NUM_RX-1:0]    rx_line_valid,
    input  wire logic [NUM_RX-1:0]    rx_line_level,
    input  wire logic [1:0]           rail_above_limit,
    output logic [NUM_TX-1:0]         tx_line_out,
    output logic [NUM_TX-1:0]         tx_line_oe,
    output logic [NUM_RX-1:0]         rx_logic_out,
    output logic [NUM_RX-1:0]         rx_logic_oe,
    output logic [NUM_MON-1:0]        monitor_rx_out,
    output logic                      line_active,
    output logic [1:0]                pump_on,
    output logic [1:0]                rail_tied,
    output logic                      tx_ready
);
    typedef struct packed {
        stx_pkg::stx_mode_t mode;
        logic [3:0]         ctrl;
        logic [NUM_TX-1:0]  tx_data;
        logic [NUM_TX-1:0]  tx_out;
        logic [NUM_TX-1:0]  tx_oe;
        logic [NUM_RX-1:0]  rx_out;
        logic [NUM_RX-1:0]  rx_oe;
        logic [NUM_MON-1:0] mon;
        logic               active;
        logic [31:0]        prdata;
    } stx_ctrl_st_t;

    stx_ctrl_st_t state_reg;
    stx_ctrl_st_t state_next;

    logic any_valid;
    logic keep_on_eff;
    logic hard_off_eff;
    logic multi;
    logic rx_dis_eff;
    logic auto_allowed;
    logic idle_done;
    logic wake_done;
    logic powered;
    logic [1:0] pump_on_w;
    logic [1:0] rail_tied_w;
    logic apb_access;

    assign any_valid    = |rx_line_valid;
    // pins and software controls combine: either can assert
    assign keep_on_eff  = keep_on_request | state_reg.ctrl[stx_pkg::CTRL_KEEP_ON];
    assign hard_off_eff = ~hard_off_n | ~state_reg.ctrl[stx_pkg::CTRL_HARD_OFF];
    assign rx_dis_eff   = rx_disable | state_reg.ctrl[stx_pkg::CTRL_RX_DIS];
    assign multi        = state_reg.ctrl[stx_pkg::CTRL_MULTI];
    assign auto_allowed = ~keep_on_eff & ~hard_off_eff;
    assign powered      = (state_reg.mode == stx_pkg::STX_WAKE)
                        | (state_reg.mode == stx_pkg::STX_RUN);
    assign apb_access   = apb_req.psel & apb_req.penable;

    // any valid level restarts the idle interval
    stx_timer #(
        .CNT_W  (stx_pkg::CNT_W),
        .CYCLES (stx_pkg::IDLE_CYCLES)
    ) u_idle (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .restart (any_valid | ~auto_allowed),
        .done    (idle_done)
    );

    // wake delay restarts whenever the mode is neither wake nor run (pumps not enabled)
    stx_timer #(
        .CNT_W  (stx_pkg::CNT_W),
        .CYCLES (stx_pkg::WAKE_CYCLES)
    ) u_wake (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .restart (~powered),
        .done    (wake_done)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pump
            stx_pump u_pump (
                .mclk        (mclk),
                .rst_b       (rst_b),
                .enable      (powered),
                .above_limit (rail_above_limit[gi]),
                .pump_on     (pump_on_w[gi]),
                .rail_tied   (rail_tied_w[gi])
            );
        end
    endgenerate

    always_comb begin
        state_next = state_reg;

        unique case (state_reg.mode)
            stx_pkg::STX_OFF: begin
                if (!hard_off_eff && (keep_on_eff || any_valid)) begin
                    state_next.mode = stx_pkg::STX_WAKE;
                end
            end
            stx_pkg::STX_WAKE: begin
                if (wake_done) begin
                    state_next.mode = stx_pkg::STX_RUN;
                end
            end
            stx_pkg::STX_RUN: begin
                state_next.mode = stx_pkg::STX_RUN;
            end
            stx_pkg::STX_IDLE: begin
                if (keep_on_eff || any_valid) begin
                    state_next.mode = stx_pkg::STX_WAKE;
                end
            end
        endcase
        // hard-off wins over everything
        if (hard_off_eff) begin
            state_next.mode = stx_pkg::STX_OFF;
        end else if (powered && auto_allowed && idle_done && !any_valid) begin
            state_next.mode = stx_pkg::STX_IDLE;
        end

        // transmitters driven only while powered
        state_next.tx_oe  = {NUM_TX{(state_next.mode == stx_pkg::STX_WAKE)
                                  | (state_next.mode == stx_pkg::STX_RUN)}};
        state_next.tx_out = ~state_reg.tx_data;

        state_next.rx_out = ~rx_line_level;
        if (multi) begin
            state_next.rx_oe = {NUM_RX{~hard_off_eff}};
        end else begin
            state_next.rx_oe = {NUM_RX{~rx_dis_eff}};
        end
        // monitors carry the first receivers' line level, never released
        state_next.mon    = rx_line_level[NUM_MON-1:0];
        state_next.active = any_valid;

        // apb: write at the access edge, read data registered from setup
        if (apb_req.psel && !apb_req.penable) begin
            unique case (apb_req.paddr)
                stx_pkg::ADDR_CTRL:   state_next.prdata = {28'h0, state_reg.ctrl};
                stx_pkg::ADDR_STATUS: state_next.prdata = {26'h0,
                    |state_reg.rx_oe, state_reg.active, pump_on_w,
                    state_reg.mode == stx_pkg::STX_RUN, powered};
                stx_pkg::ADDR_TXDATA: state_next.prdata = 32'(state_reg.tx_data);
                stx_pkg::ADDR_RXDATA: state_next.prdata = 32'(rx_line_level);
                default:              state_next.prdata = 32'h0;
            endcase
        end
        if (apb_access && apb_req.pwrite) begin
            if (apb_req.paddr == stx_pkg::ADDR_CTRL) begin
                state_next.ctrl = apb_req.pwdata[3:0];
            end else if (apb_req.paddr == stx_pkg::ADDR_TXDATA) begin
                state_next.tx_data = apb_req.pwdata[NUM_TX-1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg        <= '0;
            state_reg.mode   <= stx_pkg::STX_OFF;
            state_reg.ctrl   <= stx_pkg::CTRL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tx_line_out     = state_reg.tx_out;
    assign tx_line_oe      = state_reg.tx_oe;
    assign rx_logic_out    = state_reg.rx_out;
    assign rx_logic_oe     = state_reg.rx_oe;
    assign monitor_rx_out  = state_reg.mon;
    assign line_active     = state_reg.active;
    assign pump_on         = pump_on_w;
    assign rail_tied       = rail_tied_w;
    assign tx_ready        = (state_reg.mode == stx_pkg::STX_RUN);
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_access & ~((apb_req.paddr == stx_pkg::ADDR_CTRL)
                           | (apb_req.paddr == stx_pkg::ADDR_STATUS)
                           | (apb_req.paddr == stx_pkg::ADDR_TXDATA)
                           | (apb_req.paddr == stx_pkg::ADDR_RXDATA));
    assign apb_rsp.prdata  = state_reg.prdata;
endmodule

// ==== src/stx_pkg.sv ====
// package: shared constants and carriers for the transceiver mode control
package stx_pkg;
    localparam int CLK_HZ          = 40_000_000;
    localparam int IDLE_TIMEOUT_US = 30;
    localparam int WAKE_TIME_US    = 100;
    // least times round down to whole cycles
    localparam int IDLE_CYCLES = (IDLE_TIMEOUT_US * (CLK_HZ / 1_000_000));
    localparam int WAKE_CYCLES = (WAKE_TIME_US * (CLK_HZ / 1_000_000));
    localparam int CNT_W       = 16;
    localparam int NUM_TX      = 3;
    localparam int NUM_RX      = 5;
    localparam int NUM_MON     = 2;
    // address map of the apb slave
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0c;
    // control fields
    localparam int CTRL_KEEP_ON  = 0;
    localparam int CTRL_HARD_OFF = 1;
    localparam int CTRL_RX_DIS   = 2;
    localparam int CTRL_MULTI    = 3;
    localparam logic [3:0] CTRL_RESET = 4'h2;
    // status fields
    localparam int ST_ACTIVE  = 0;
    localparam int ST_READY   = 1;
    localparam int ST_PUMP_P  = 2;
    localparam int ST_PUMP_N  = 3;
    localparam int ST_FLAG    = 4;
    localparam int ST_RX_EN   = 5;

    typedef enum logic [1:0] {STX_OFF, STX_WAKE, STX_RUN, STX_IDLE} stx_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } stx_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } stx_apb_rsp_t;
endpackage

// ==== src/stx_pump.sv ====
// module: one discontinuous charge pump regulator
`timescale 1ns/1ps
module stx_pump (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic enable,
    input  wire logic above_limit,
    output logic      pump_on,
    output logic      rail_tied
);
    typedef struct packed {
        logic pump;
        logic tied;
    } stx_pump_st_t;
    stx_pump_st_t state_reg;
    stx_pump_st_t state_next;

    always_comb begin
        state_next      = state_reg;
        // pump only while magnitude is under the limit
        state_next.pump = enable & ~above_limit;
        // while off, rail is tied to supply or ground
        state_next.tied = ~enable;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '{pump: 1'b0, tied: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pump_on   = state_reg.pump;
    assign rail_tied = state_reg.tied;
endmodule

// ==== src/stx_timer.sv ====
// module: restartable down counter giving a done level after a delay
`timescale 1ns/1ps
module stx_timer #(
    parameter int CNT_W  = 16,
    parameter int CYCLES = 1200
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic restart,
    output logic      done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } stx_tmr_st_t;
    stx_tmr_st_t state_reg;
    stx_tmr_st_t state_next;

    always_comb begin
        state_next = state_reg;
        if (restart) begin
            state_next.cnt  = CNT_W'(CYCLES - 1);
            state_next.done = 1'b0;
        end else if (state_reg.cnt != '0) begin
            state_next.cnt = state_reg.cnt - 1'b1;
        end else begin
            state_next.done = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '{cnt: '0, done: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign done = state_reg.done;
endmodule
